// *** pfg_pkg.sv ***
package pfg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] PFG_CFG_IDX = 10'h09E;
	localparam logic [9:0] PFG_STAT_IDX = 10'h0C0;

	// Reset value of the divider configuration
	localparam logic [23:0] PFG_CFG_RST = 24'h000000;

	// Top field code that selects frame-pulse shaping
	localparam logic [3:0] PFG_FRAME_CODE = 4'hF;

	// Largest ratio software may program for the plain clock
	localparam logic [23:0] PFG_RATIO_MAX = 24'hEFFFFF;

	// Smallest ratio that produces a toggling output
	localparam logic [23:0] PFG_RATIO_MIN = 24'h000002;

	// Status word bit positions
	localparam int PFG_STAT_FRAME_POS = 0;
	localparam int PFG_STAT_OUT_POS = 1;
	localparam int PFG_STAT_RUN_POS = 2;
	localparam int PFG_STAT_BADSEL_POS = 3;

	// Counter reset values
	localparam logic [15:0] PFG_PERIOD_CNT_RST = 16'h0000;
	localparam logic [23:0] PFG_DIV_CNT_RST = 24'h000000;

	// Related clock selection codes
	typedef enum logic [1:0] {
		PFG_SEL_A = 2'b00,
		PFG_SEL_B = 2'b01,
		PFG_SEL_RSVD = 2'b10,
		PFG_SEL_D = 2'b11
	} pfg_sel_e;

	// Divider configuration layout, bit 23 down to bit 0
	typedef struct packed {
		logic [3:0] mode;
		logic style;
		logic polar;
		logic [1:0] sel;
		logic [15:0] period;
	} pfg_cfg_s;

endpackage

// *** pfg_ratio_div.sv ***
`timescale 1ns/1ps

module pfg_ratio_div
	import pfg_pkg::*;
(
	input wire logic clk_i, // VCO clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic en_i, // Plain clock mode active
	input wire logic [23:0] ratio_i, // Division ratio
	output logic div_o // Divided clock
);

	logic [23:0] cnt_reg;
	logic [23:0] cnt_next;
	logic out_reg;
	logic out_next;
	logic [23:0] half;
	logic active;
	logic live_reg;
	logic live_next;
	logic [23:0] ratio_reg;
	logic [23:0] ratio_next;
	logic restart;

	assign half = {1'b0, ratio_i[23:1]};
	assign active = en_i && (ratio_i >= PFG_RATIO_MIN);
	// Start each new ratio at count zero so the first high phase is whole
	assign restart = !live_reg || (ratio_i != ratio_reg);

	always_comb begin
		cnt_next = PFG_DIV_CNT_RST;
		if (active && !restart && (cnt_reg < ratio_i - 24'h000001)) begin
			cnt_next = cnt_reg + 24'h000001;
		end
		out_next = active && (cnt_next < half);
		live_next = active;
		ratio_next = ratio_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= PFG_DIV_CNT_RST;
			out_reg <= 1'b0;
			live_reg <= 1'b0;
			ratio_reg <= PFG_CFG_RST;
		end else begin
			cnt_reg <= cnt_next;
			out_reg <= out_next;
			live_reg <= live_next;
			ratio_reg <= ratio_next;
		end
	end

	assign div_o = out_reg;

	chk_div_rise_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(div_o) |-> (cnt_reg == PFG_DIV_CNT_RST))
		else $error("divided clock rose away from count wrap");

	chk_div_fall_half: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(div_o) && $stable(ratio_i) && $past(active)) |-> (cnt_reg == half))
		else $error("divided clock fell away from half ratio");

endmodule // pfg_ratio_div

// *** pfg_tb.sv ***
`timescale 1ns/1ps

module testbench;
	import pfg_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [4:0] rel_cnt = 5'h00;
	logic clk_out_o;
	logic [31:0] rd;
	logic [31:0] rises;
	logic [31:0] highs;
	logic [31:0] tr;
	logic [1:0] rel_hist = 2'b00;
	logic lead_rel;
	pfg_cfg_s cfg;
	int failures = 0;
	int tests_run = 0;

	// Sibling clocks of period 4, 6 and 8 cycles
	wire rel_clk_a_i = rel_cnt[1];
	wire rel_clk_b_i = (rel_cnt % 5'h06) < 5'h03;
	wire rel_clk_d_i = rel_cnt[2];

	pfg_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rel_clk_a_i(rel_clk_a_i), .rel_clk_b_i(rel_clk_b_i), .rel_clk_d_i(rel_clk_d_i), .clk_out_o(clk_out_o));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		rel_cnt <= (rel_cnt == 5'h17) ? 5'h00 : rel_cnt + 5'h01;
	end

	// Level history of the related clock that the current setting selects
	always @(posedge clk_i) begin
		rel_hist <= {rel_hist[0], (cfg.sel == PFG_SEL_A) ? rel_clk_a_i : (cfg.sel == PFG_SEL_B) ? rel_clk_b_i : rel_clk_d_i};
	end

	task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		if (n >= 100) failures++;
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Counts rising edges and high cycles of the output over n cycles
	task automatic measure(input int n);
		logic prev;
		prev = clk_out_o;
		rises = 32'h0;
		highs = 32'h0;
		lead_rel = 1'bx;
		repeat (n) begin
			@(posedge clk_i);
			if (clk_out_o === 1'b1 && prev === 1'b0) rises++;
			// Related level at the event that started the pulse, two cycles back
			if (clk_out_o === ~cfg.polar && prev === cfg.polar) lead_rel = rel_hist[1];
			if (clk_out_o === 1'b1) highs++;
			prev = clk_out_o;
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, 12'h278, 32'h0, rd);
		check(rd, {8'h00, PFG_CFG_RST});
		wb_xfer(1'b1, 12'h278, 32'hFF5A3C96, rd);
		wb_xfer(1'b0, 12'h278, 32'h0, rd);
		check(rd, 32'h005A3C96);
		wb_xfer(1'b0, 12'h100, 32'h0, rd);
		check(rd, 32'h0);
		$display("register test done");
		for (int n = 2; n <= 5; n++) begin
			wb_xfer(1'b1, 12'h278, n, rd);
			repeat (20) @(posedge clk_i);
			measure(10 * n);
			check(rises, 32'd10);
			check(highs, 10 * (n / 2));
		end
		$display("plain clock test done");
		for (int i = 0; i < 8; i++) begin
			cfg.mode = PFG_FRAME_CODE;
			cfg.sel = i[1:0];
			cfg.polar = i[2];
			cfg.style = i[0] ^ i[2];
			cfg.period = 16'h0003;
			tr = (i[1:0] == 2'b00) ? 32'd4 : (i[1:0] == 2'b01) ? 32'd6 : 32'd8;
			wb_xfer(1'b1, 12'h278, {8'h00, cfg}, rd);
			repeat (60) @(posedge clk_i);
			measure(12 * tr);
			if (cfg.sel == PFG_SEL_RSVD) begin
				check(rises, 32'd0);
				check(highs, cfg.polar ? 12 * tr : 32'd0);
				wb_xfer(1'b0, 12'h300, 32'h0, rd);
				check(rd, {28'h0000000, 1'b1, 1'b0, cfg.polar, 1'b1});
			end else begin
				check(rises, 32'd4);
				check(highs, cfg.polar ? 8 * tr : 4 * tr);
				check({31'h00000000, lead_rel}, {31'h00000000, cfg.style});
			end
		end
		$display("frame pulse test done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, 12'h278, 32'h0, rd);
		check(rd, {8'h00, PFG_CFG_RST});
		$display("mid-run reset test done");
		final_report();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		final_report();
	end
endmodule // testbench

// *** pfg_top.sv ***
`timescale 1ns/1ps

// Summary of operation
// - Top field all ones shapes the output as frame pulses from the low bits.
// - Any other top field with a ratio of at least two gives a clock high for half the ratio rounded down, whole value is ratio.
// - Low sixteen bits count related clock periods between two frame pulses.
// - Two bits pick related clock A, B or D; code two is reserved.
// - Each frame pulse lasts exactly one related clock period; a period field of one holds the pulse on.
// - Polarity bit zero gives normal pulse, one gives inverted pulse.
// - Style bit zero centres the boundary in pulse; one puts it on edge.
// - Plain mode divides the VCO clock by the programmed ratio.
// - Configuration resets to zero and is readable and writable.
module pfg_top
	import pfg_pkg::*;
(
	input wire logic clk_i, // VCO clock, 200 MHz
	input wire logic rst_i, // Synchronous reset, high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [11:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic rel_clk_a_i, // Sibling divider A output
	input wire logic rel_clk_b_i, // Sibling divider B output
	input wire logic rel_clk_d_i, // Sibling divider D output
	output logic clk_out_o // Divider output
);

	pfg_cfg_s cfg_reg;
	pfg_cfg_s cfg_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic req;
	logic wr_take;
	logic cfg_hit;
	logic stat_hit;
	logic [23:0] wr_merged;
	logic [31:0] stat_word;

	logic rel_now;
	logic sel_ok;
	logic rel_prev_reg;
	logic rel_prev_next;
	logic rel_rise;
	logic rel_fall;
	logic fp_event;
	logic frame_mode;
	logic run;
	logic [15:0] period_m1;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic pulse_reg;
	logic pulse_next;
	logic out_reg;
	logic out_next;
	logic div_clk;

	// Register bus decode
	assign req = wb_cyc_i && wb_stb_i;
	assign wr_take = req && ack_reg && wb_we_i;
	assign cfg_hit = (wb_adr_i[11:2] == PFG_CFG_IDX);
	assign stat_hit = (wb_adr_i[11:2] == PFG_STAT_IDX);

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_lane
			assign wr_merged[8*g +: 8] = wb_sel_i[g] ? wb_dat_i[8*g +: 8] : cfg_reg[8*g +: 8];
		end
	endgenerate

	always_comb begin
		stat_word = 32'h00000000;
		stat_word[PFG_STAT_FRAME_POS] = frame_mode;
		stat_word[PFG_STAT_OUT_POS] = out_reg;
		stat_word[PFG_STAT_RUN_POS] = run;
		stat_word[PFG_STAT_BADSEL_POS] = frame_mode && !sel_ok;
	end

	always_comb begin
		cfg_next = cfg_reg;
		ack_next = 1'b0;
		dat_next = dat_reg;
		if (req && !ack_reg) begin
			ack_next = 1'b1;
			dat_next = 32'h00000000;
			if (!wb_we_i && cfg_hit) begin
				dat_next = {8'h00, cfg_reg};
			end else if (!wb_we_i && stat_hit) begin
				dat_next = stat_word;
			end
		end
		if (wr_take && cfg_hit) begin
			cfg_next = pfg_cfg_s'(wr_merged);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= pfg_cfg_s'(PFG_CFG_RST);
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			cfg_reg <= cfg_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	assign frame_mode = (cfg_reg.mode == PFG_FRAME_CODE);

	always_comb begin
		rel_now = 1'b0;
		sel_ok = 1'b1;
		unique case (pfg_sel_e'(cfg_reg.sel))
			PFG_SEL_A: rel_now = rel_clk_a_i;
			PFG_SEL_B: rel_now = rel_clk_b_i;
			PFG_SEL_D: rel_now = rel_clk_d_i;
			PFG_SEL_RSVD: sel_ok = 1'b0;
		endcase
	end

	assign rel_rise = rel_now && !rel_prev_reg;
	assign rel_fall = !rel_now && rel_prev_reg;
	assign fp_event = cfg_reg.style ? rel_rise : rel_fall;
	assign run = frame_mode && sel_ok && (cfg_reg.period != PFG_PERIOD_CNT_RST);
	assign period_m1 = cfg_reg.period - 16'h0001;

	always_comb begin
		rel_prev_next = rel_now;
		cnt_next = cnt_reg;
		pulse_next = pulse_reg;
		if (!run) begin
			cnt_next = PFG_PERIOD_CNT_RST;
			pulse_next = 1'b0;
		end else if (fp_event) begin
			if (cnt_reg >= period_m1) begin
				cnt_next = PFG_PERIOD_CNT_RST;
				pulse_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 16'h0001;
				pulse_next = 1'b0;
			end
		end
	end

	always_comb begin
		out_next = frame_mode ? (pulse_reg ^ cfg_reg.polar) : div_clk;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rel_prev_reg <= 1'b0;
			cnt_reg <= PFG_PERIOD_CNT_RST;
			pulse_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			rel_prev_reg <= rel_prev_next;
			cnt_reg <= cnt_next;
			pulse_reg <= pulse_next;
			out_reg <= out_next;
		end
	end

	assign clk_out_o = out_reg;

	// ratio carries the frame code too; en_i holds the divider off then
	pfg_ratio_div u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(!frame_mode),
		.ratio_i(cfg_reg),
		.div_o(div_clk)
	);

	chk_cfg_reset_zero: assert property (@(posedge clk_i)
		rst_i |=> (cfg_reg == pfg_cfg_s'(PFG_CFG_RST)))
		else $error("configuration not zero after reset");

	chk_cfg_write_lane: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_take && cfg_hit && wb_sel_i[0]) |=> (cfg_reg[7:0] == $past(wb_dat_i[7:0])))
		else $error("configuration low byte write lost");

	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !ack_reg) |=> (wb_ack_o ##1 !wb_ack_o))
		else $error("acknowledge not a single cycle");

	chk_frame_output: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(frame_mode) |-> (clk_out_o == ($past(pulse_reg) ^ $past(cfg_reg.polar))))
		else $error("frame mode output not from pulse shaper");

	chk_plain_output: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(frame_mode) |-> (clk_out_o == $past(div_clk)))
		else $error("plain mode output not from divider");

	chk_period_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		(run && fp_event) |=> (pulse_reg == ($past(cnt_reg) >= $past(period_m1))))
		else $error("pulse spacing count wrong");

	chk_reserved_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(frame_mode && !sel_ok) |=> !pulse_reg)
		else $error("pulse produced with reserved select");

	chk_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
		($changed(pulse_reg) && $past(run)) |-> $past(fp_event))
		else $error("pulse edge without related clock event");

	chk_idle_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
		(frame_mode && !run) ##1 (frame_mode && !run) |=> (clk_out_o == $past(cfg_reg.polar)))
		else $error("idle frame output has wrong sense");

	chk_style_edge: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pulse_reg) |-> ($past(cfg_reg.style) ? $past(rel_rise) : $past(rel_fall)))
		else $error("pulse started on wrong related edge");

endmodule // pfg_top
